// File: design/fsrw_top.sv
`include "fsrw_defines.svh"
`timescale 1ns/1ps
`default_nettype none

module fsrw_top #(
    parameter logic [7:0] SUSPEND_OPCODE = `FSRW_OP_SUSPEND_DEF
) (
    input wire logic sys_clk, // core clock
    input wire logic rst_n, // reset, low active; synchronous in the core, asynchronous in the link
    input wire logic spi_sclk, // serial clock from host
    input wire logic spi_cs_n, // chip select, low active
    input wire logic [3:0] spi_io, // data lines, io0 is serial in
    input wire logic prog_req, // pulse: program wants to start
    input wire logic erase_req, // pulse: erase wants to start
    input wire logic [23:0] req_addr, // target of prog_req or erase_req
    input wire logic [1:0] erase_size, // block size of erase_req
    input wire logic op_can_suspend, // running operation may be suspended
    input wire logic op_done, // pulse: running operation finished
    output logic prog_go, // pulse: start program engine
    output logic erase_go, // pulse: start erase engine
    output logic eng_suspend, // pulse: freeze running engine
    output logic eng_resume, // pulse: continue frozen engine
    output logic eng_resume_is_erase, // which engine eng_resume addresses
    output logic busy_flag, // operation in progress
    output logic program_suspended_flag, // a program is suspended
    output logic erase_suspended_flag, // an erase is suspended
    output logic any_suspended_flag, // something is suspended
    output logic resume_pending, // resume latency still running
    output logic wrap_enable, // wrapped quad reads active
    output logic [1:0] wrap_len_sel, // 0:8 1:16 2:32 3:64 bytes
    input wire logic rd_start, // pulse: load read address
    input wire logic rd_quad, // read being started is quad io
    input wire logic [23:0] rd_start_addr, // first byte of the read
    input wire logic rd_step, // pulse: advance read address
    input wire logic [7:0] arr_data, // array byte at rd_addr
    output logic [23:0] rd_addr, // current read address
    output logic [7:0] rd_data, // byte for the host, masked
    output logic rd_in_suspended // last rd_data was masked
);

    // ---------------- link domain ----------------

    // frame start is the first sclk edge after cs falls;
    // live clears asynchronously with cs so no edge is needed after a frame
    logic link_clr;
    logic live_q;
    logic frame_tog_q;
    fsrw_pkg::fsrw_frame_s frame_q;
    logic [5:0] clk_next;

    assign link_clr = spi_cs_n | ~rst_n;
    assign clk_next = live_q ? frame_q.clks : 6'h00;

    // frame live marker
    always_ff @(posedge spi_sclk or posedge link_clr) begin
        if (link_clr) begin
            live_q <= 1'b0;
        end else begin
            live_q <= 1'b1;
        end
    end

    // one toggle per frame tells the core a new frame happened
    always_ff @(posedge spi_sclk or negedge rst_n) begin
        if (!rst_n) begin
            frame_tog_q <= 1'b0;
        end else if (!live_q) begin
            frame_tog_q <= ~frame_tog_q;
        end
    end

    // clock count, saturating; held after cs rises for the core to read
    always_ff @(posedge spi_sclk or negedge rst_n) begin
        if (!rst_n) begin
            frame_q.clks <= 6'h00;
        end else if (clk_next != 6'h3f) begin
            frame_q.clks <= 6'(clk_next + 6'h01);
        end
    end

    // opcode shifts in on io0, msb first
    always_ff @(posedge spi_sclk or negedge rst_n) begin
        if (!rst_n) begin
            frame_q.opcode <= 8'h00;
        end else if (clk_next < `FSRW_OPCODE_CLKS) begin
            frame_q.opcode <= {frame_q.opcode[6:0], spi_io[0]};
        end
    end

    // wrap byte on four lines after six address clocks; address dropped
    always_ff @(posedge spi_sclk or negedge rst_n) begin
        if (!rst_n) begin
            frame_q.wrap_bits <= 8'h00;
        end else if (clk_next == `FSRW_WRAP_HI_CLK) begin
            frame_q.wrap_bits[7:4] <= spi_io;
        end else if (clk_next == `FSRW_WRAP_LO_CLK) begin
            frame_q.wrap_bits[3:0] <= spi_io;
        end
    end

    // ---------------- core domain ----------------

    // cs and frame toggle pass two flops before use
    logic cs_s1_q;
    logic cs_s2_q;
    logic cs_s3_q;
    logic tog_s1_q;
    logic tog_s2_q;
    logic tog_seen_q;

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            cs_s1_q <= 1'b1;
            cs_s2_q <= 1'b1;
            cs_s3_q <= 1'b1;
            tog_s1_q <= 1'b0;
            tog_s2_q <= 1'b0;
        end else begin
            cs_s1_q <= spi_cs_n;
            cs_s2_q <= cs_s1_q;
            cs_s3_q <= cs_s2_q;
            tog_s1_q <= frame_tog_q;
            tog_s2_q <= tog_s1_q;
        end
    end

    // frame end: cs went high and a frame with clocks really happened;
    // frame_q is quiet by now because sclk stops before cs rises
    logic frame_end;
    assign frame_end = cs_s2_q & ~cs_s3_q & (tog_s2_q != tog_seen_q);

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            tog_seen_q <= 1'b0;
        end else if (frame_end) begin
            tog_seen_q <= tog_s2_q;
        end
    end

    // command decode of the finished frame
    logic byte_ok;
    logic is_suspend;
    logic is_resume;
    logic is_wrap;

    // whole opcode, cs released on a multiple of eight bits
    assign byte_ok = (frame_q.clks[2:0] == 3'h0) && (frame_q.clks >= `FSRW_OPCODE_CLKS);
    // no write enable latch term: suspend and resume never look at it
    assign is_suspend = frame_end && byte_ok && frame_q.opcode == SUSPEND_OPCODE;
    assign is_resume = frame_end && byte_ok && (frame_q.opcode == `FSRW_OP_RESUME_A ||
        frame_q.opcode == `FSRW_OP_RESUME_B);
    // quad phase carries four bits a clock, so an even count of 16 or more is whole bytes
    assign is_wrap = frame_end && frame_q.opcode == `FSRW_OP_SET_WRAP &&
        frame_q.clks >= `FSRW_WRAP_CLKS && !frame_q.clks[0];

    // operation state and flags
    fsrw_pkg::fsrw_run_e run_q;
    logic busy_q;
    logic ps_q;
    logic es_q;
    logic [15:0] res_cnt_q;
    logic res_wait;
    logic take_prog;
    logic take_erase;
    logic take_suspend;
    logic take_resume;

    assign res_wait = res_cnt_q != 16'h0000;
    // program may start during an erase suspend, never on top of a suspended program
    assign take_prog = prog_req && !busy_q && !ps_q;
    assign take_erase = erase_req && !busy_q && !ps_q && !es_q;
    assign take_suspend = is_suspend && busy_q && op_can_suspend && !res_wait &&
        run_q != fsrw_pkg::FSRW_RUN_IDLE;
    assign take_resume = is_resume && (ps_q || es_q) && !busy_q;

    // owner of the array engine
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            run_q <= fsrw_pkg::FSRW_RUN_IDLE;
        end else if (take_prog) begin
            run_q <= fsrw_pkg::FSRW_RUN_PROG;
        end else if (take_erase) begin
            run_q <= fsrw_pkg::FSRW_RUN_ERASE;
        end else if (take_resume) begin
            run_q <= ps_q ? fsrw_pkg::FSRW_RUN_PROG : fsrw_pkg::FSRW_RUN_ERASE;
        end else if (take_suspend || op_done) begin
            run_q <= fsrw_pkg::FSRW_RUN_IDLE;
        end
    end

    // busy: set by a start or a resume, cleared by suspend or completion
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            busy_q <= 1'b0;
        end else if (take_prog || take_erase || take_resume) begin
            busy_q <= 1'b1;
        end else if (take_suspend || op_done) begin
            busy_q <= 1'b0;
        end
    end

    // suspended flags; set and clear never meet since one needs busy, the other idle
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            ps_q <= 1'b0;
            es_q <= 1'b0;
        end else if (take_suspend) begin
            case (run_q)
                fsrw_pkg::FSRW_RUN_PROG: begin
                    ps_q <= 1'b1;
                end
                fsrw_pkg::FSRW_RUN_ERASE: begin
                    es_q <= 1'b1;
                end
                default: begin
                    ps_q <= ps_q;
                end
            endcase
        end else if (take_resume) begin
            // program first; the erase waits for a second resume
            if (ps_q) begin
                ps_q <= 1'b0;
            end else begin
                es_q <= 1'b0;
            end
        end
    end

    // status outputs; any-suspended is registered in the same cycle as the two flags
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            busy_flag <= 1'b0;
            program_suspended_flag <= 1'b0;
            erase_suspended_flag <= 1'b0;
            any_suspended_flag <= 1'b0;
        end else begin
            busy_flag <= busy_q;
            program_suspended_flag <= ps_q;
            erase_suspended_flag <= es_q;
            any_suspended_flag <= ps_q | es_q;
        end
    end

    // resume latency window; suspends are dropped while it runs
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            res_cnt_q <= 16'h0000;
        end else if (take_resume) begin
            res_cnt_q <= 16'(`FSRW_RESUME_CYC);
        end else if (res_wait) begin
            res_cnt_q <= 16'(res_cnt_q - 16'h0001);
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            resume_pending <= 1'b0;
        end else begin
            resume_pending <= take_resume | (res_wait && res_cnt_q != 16'h0001);
        end
    end

    // engine strobes; resume goes out the cycle after frame end, well inside the latency
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            prog_go <= 1'b0;
            erase_go <= 1'b0;
            eng_suspend <= 1'b0;
            eng_resume <= 1'b0;
            eng_resume_is_erase <= 1'b0;
        end else begin
            prog_go <= take_prog;
            erase_go <= take_erase;
            eng_suspend <= take_suspend;
            eng_resume <= take_resume;
            if (take_resume) begin
                eng_resume_is_erase <= !ps_q;
            end
        end
    end

    // suspended areas, recorded when the operation starts
    logic [15:0] prog_page_q;
    logic [23:0] erase_base_q;
    logic [23:0] erase_mask_q;

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            prog_page_q <= 16'h0000;
        end else if (take_prog) begin
            prog_page_q <= req_addr[23:8];
        end
    end

    // the mask keeps the in-block offset bits so a compare sees only the block
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            erase_base_q <= 24'h000000;
            erase_mask_q <= 24'h000fff;
        end else if (take_erase) begin
            erase_base_q <= req_addr;
            case (fsrw_pkg::fsrw_esize_e'(erase_size))
                fsrw_pkg::FSRW_ERASE_32K: begin
                    erase_mask_q <= 24'h007fff;
                end
                fsrw_pkg::FSRW_ERASE_64K: begin
                    erase_mask_q <= 24'h00ffff;
                end
                default: begin
                    erase_mask_q <= 24'h000fff;
                end
            endcase
        end
    end

    // wrap setting; unused wrap bits are never looked at
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            wrap_enable <= 1'b0;
            wrap_len_sel <= 2'h0;
        end else if (is_wrap) begin
            wrap_enable <= !frame_q.wrap_bits[`FSRW_WRAP_DIS];
            wrap_len_sel <= {frame_q.wrap_bits[`FSRW_WRAP_LEN_HI],
                frame_q.wrap_bits[`FSRW_WRAP_LEN_LO]};
        end
    end

    // read address counter; wrap enable is sampled per read so a change of it mid-read waits; wrap_len_sel is used live
    logic rd_wrap_q;
    logic [5:0] line_mask;
    logic [5:0] low_inc;
    logic [23:0] next_addr;

    assign line_mask = 6'(({3'h0, 3'h7} << wrap_len_sel) | 6'h07);
    assign low_inc = 6'(rd_addr[5:0] + 6'h01);

    always_comb begin
        if (rd_wrap_q) begin
            // stay inside the aligned line, folding to its start
            next_addr = {rd_addr[23:6], (rd_addr[5:0] & ~line_mask) | (low_inc & line_mask)};
        end else begin
            next_addr = 24'(rd_addr + 24'h000001);
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            rd_addr <= 24'h000000;
            rd_wrap_q <= 1'b0;
        end else if (rd_start) begin
            rd_addr <= rd_start_addr;
            rd_wrap_q <= rd_quad && wrap_enable;
        end else if (rd_step) begin
            rd_addr <= next_addr;
        end
    end

    // area hit for the current address; reads are never refused, only masked
    logic hit_prog;
    logic hit_erase;

    assign hit_prog = ps_q && rd_addr[23:8] == prog_page_q;
    assign hit_erase = es_q && (rd_addr & ~erase_mask_q) == (erase_base_q & ~erase_mask_q);

    // byte for the host; undefined inside the area, valid again once past it
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            rd_data <= `FSRW_UNDEF_BYTE;
            rd_in_suspended <= 1'b0;
        end else begin
            rd_data <= (hit_prog || hit_erase) ? `FSRW_UNDEF_BYTE : arr_data;
            rd_in_suspended <= hit_prog || hit_erase;
        end
    end

endmodule

`default_nettype wire

// File: design/fsrw_defines.svh
// How it works
// - a program may start while an erase is suspended; erase resumes after it
// - while a program is suspended, erase start requests are refused
// - suspended state never blocks reads or commands other than program and erase starts
// - suspend is honoured whatever the write enable latch holds
// - suspend acts only for a whole opcode ended on a byte boundary
// - reads inside the suspended page or block return undefined data
// - sequential reads turn undefined inside the suspended area, valid outside
// - both resume opcodes decode to one identical action
// - resume is taken only with a suspended flag set and busy clear
// - resume is honoured whatever the write enable latch holds
// - resume is an eight clock opcode on one line, msb first, nothing more; the code also takes 16 to 56 clocks in steps of eight
// - resume clears the matching suspended flag, then any-suspended when both clear
// - resume sets the busy flag
// - the resumed operation restarts at frame end within the resume latency
// - resume acts only for a whole opcode ended on a byte boundary
// - suspend is ignored while a resume is still taking effect
// - with both suspended, resume restarts the program first
// - wrap command: opcode, six quad address clocks treated as don't care
// - of the wrap byte only bits six to four are used
// - bit four low enables wrap; bits six and five pick 8 to 64 bytes
// - wrapped quad reads run to the line end and then back to its start
// - a wrap command with bit four high returns to linear reads
// - a suspend sets any-suspended and the matching flag and clears busy
// - a wrap command not ended on a byte boundary changes nothing
`ifndef FSRW_DEFINES_SVH
`define FSRW_DEFINES_SVH

`define FSRW_OP_RESUME_A 8'h7a
`define FSRW_OP_RESUME_B 8'hd0
`define FSRW_OP_SET_WRAP 8'h77
`define FSRW_OP_SUSPEND_DEF 8'h00
`define FSRW_OPCODE_CLKS 6'h08
`define FSRW_WRAP_CLKS 6'h10
`define FSRW_WRAP_HI_CLK 6'h0e
`define FSRW_WRAP_LO_CLK 6'h0f
`define FSRW_WRAP_LEN_HI 6
`define FSRW_WRAP_LEN_LO 5
`define FSRW_WRAP_DIS 4
`define FSRW_UNDEF_BYTE 8'hff
`define FSRW_CLK_PERIOD_NS 100
`define FSRW_RESUME_LATENCY_NS 20000
`define FSRW_RESUME_CYC ((`FSRW_RESUME_LATENCY_NS) / (`FSRW_CLK_PERIOD_NS))

`endif

// File: design/fsrw_pkg.sv
package fsrw_pkg;

    // what a finished frame left behind in the link domain
    typedef struct packed {
        logic [7:0] opcode;
        logic [5:0] clks;
        logic [7:0] wrap_bits;
    } fsrw_frame_s;

    // operation owning the array engine
    typedef enum logic [2:0] {
        FSRW_RUN_IDLE = 3'b001,
        FSRW_RUN_PROG = 3'b010,
        FSRW_RUN_ERASE = 3'b100
    } fsrw_run_e;

    // erase block size of the recorded erase
    typedef enum logic [1:0] {
        FSRW_ERASE_4K = 2'h0,
        FSRW_ERASE_32K = 2'h1,
        FSRW_ERASE_64K = 2'h2
    } fsrw_esize_e;

endpackage

// File: verif/fsrw_sva.sv
`timescale 1ns/1ps
`default_nettype none

module fsrw_sva (
    input wire logic sys_clk, // core clock
    input wire logic rst_n, // sync reset
    input wire logic prog_go, // program start
    input wire logic erase_go, // erase start
    input wire logic eng_suspend, // suspend taken
    input wire logic eng_resume, // resume taken
    input wire logic eng_resume_is_erase, // resume target
    input wire logic busy_flag, // busy
    input wire logic program_suspended_flag, // program held
    input wire logic erase_suspended_flag, // erase held
    input wire logic any_suspended_flag, // anything held
    input wire logic resume_pending, // latency running
    input wire logic wrap_enable, // wrap on
    input wire logic [7:0] arr_data, // array byte
    input wire logic [7:0] rd_data, // read byte
    input wire logic rd_in_suspended // byte masked
);
    default clocking dc @(posedge sys_clk);
    endclocking
    default disable iff (!rst_n);

    // suspend bookkeeping and start gating
    property p_any; any_suspended_flag == (program_suspended_flag || erase_suspended_flag); endproperty
    a_any: assert property (p_any) else $error("any flag mismatch");
    property p_erase_ok; erase_go |-> !program_suspended_flag && !erase_suspended_flag; endproperty
    a_erase_ok: assert property (p_erase_ok) else $error("erase started while held");
    property p_prog_ok; prog_go |-> !busy_flag && !program_suspended_flag; endproperty
    a_prog_ok: assert property (p_prog_ok) else $error("bad program start");
    // flags are registered once more than the strobe, so they show a cycle later
    property p_any_suspended_flag; eng_suspend |=> any_suspended_flag && !busy_flag; endproperty
    a_any_suspended_flag: assert property (p_any_suspended_flag) else $error("suspend flags wrong");

    // resume acceptance and its after-effects
    property p_res_take; eng_resume |-> $past(any_suspended_flag) && !$past(busy_flag); endproperty
    a_res_take: assert property (p_res_take) else $error("resume taken wrongly");
    property p_res_busy; eng_resume |=> busy_flag; endproperty
    a_res_busy: assert property (p_res_busy) else $error("resume not busy");
    property p_res_fall;
        $fell(program_suspended_flag) || $fell(erase_suspended_flag) |-> $past(eng_resume);
    endproperty
    a_res_fall: assert property (p_res_fall) else $error("flag fell without resume");
    property p_pend; eng_resume |=> (resume_pending && !eng_suspend) [*8]; endproperty
    a_pend: assert property (p_pend) else $error("suspend during latency");
    property p_nest; eng_resume && $past(program_suspended_flag) |-> !eng_resume_is_erase; endproperty
    a_nest: assert property (p_nest) else $error("erase resumed first");

    // read masking and reset state; the first cycle after reset has no past byte
    property p_mask; rd_in_suspended |-> rd_data == 8'hff; endproperty
    a_mask: assert property (p_mask) else $error("masked byte not ff");
    property p_pass; $past(rst_n) && !rd_in_suspended |-> rd_data == $past(arr_data); endproperty
    a_pass: assert property (p_pass) else $error("read byte wrong");
    property p_wrap_rst; $rose(rst_n) |-> !wrap_enable ##1 !wrap_enable; endproperty
    a_wrap_rst: assert property (p_wrap_rst) else $error("wrap on after reset");

    c_nest: cover property (eng_resume && eng_resume_is_erase);
    c_any_suspended_flag: cover property (eng_suspend && erase_suspended_flag);
    c_mask: cover property (rd_in_suspended);
endmodule

bind fsrw_top fsrw_sva u_sva (.*);

`default_nettype wire

// File: verif/fsrw_host.sv
`timescale 1ns/1ps
`default_nettype none

module fsrw_host (
    output logic spi_sclk, // serial clock, still between frames
    output logic spi_cs_n, // chip select
    output logic [3:0] spi_io // data lines
);
    initial begin
        spi_sclk = 1'b0;
        spi_cs_n = 1'b1;
        spi_io = 4'h5;
    end

    // mode 0 frame; n is the clock count, so short counts exercise the abort path
    task automatic frame(input logic [7:0] op, input int n, input logic [7:0] wb);
        logic [3:0] v;
        spi_cs_n = 1'b0;
        for (int i = 0; i < n; i++) begin
            if (i < 8) v = {~spi_io[3:1], op[7 - i]};
            else if (i == 14) v = wb[7:4];
            else if (i == 15) v = wb[3:0];
            else v = ~spi_io;
            #16 spi_io = v;
            #16 spi_sclk = 1'b1;
            #32 spi_sclk = 1'b0;
        end
        #32 spi_cs_n = 1'b1;
        spi_io = ~spi_io; // released lines keep no stale value
        #300;
    endtask
endmodule

`default_nettype wire

// File: verif/tb_top.sv
`timescale 1ns/1ps
`default_nettype none

module tb_top;
    localparam logic [7:0] ANY_SUSPENDED_FLAG = 8'hb0;
    logic sys_clk = 1'b0;
    logic rst_n = 1'b1;
    logic spi_sclk, spi_cs_n, prog_go, erase_go, eng_suspend, eng_resume, eng_resume_is_erase;
    logic [3:0] spi_io;
    logic prog_req = 1'b0, erase_req = 1'b0, op_done = 1'b0, op_can_suspend = 1'b1;
    logic rd_start = 1'b0, rd_quad = 1'b0, rd_step = 1'b0;
    logic [23:0] req_addr = 24'h0, rd_start_addr = 24'h0, rd_addr;
    logic [1:0] erase_size = 2'h0, wrap_len_sel;
    logic [7:0] arr_data, rd_data;
    logic busy_flag, program_suspended_flag, erase_suspended_flag, any_suspended_flag;
    logic resume_pending, wrap_enable, rd_in_suspended;
    int miscompares = 0, num_checks = 0, ticks = 0, n_pg = 0, n_eg = 0, n_sus = 0, n_res = 0;

    fsrw_top #(.SUSPEND_OPCODE(ANY_SUSPENDED_FLAG)) dut (.*);
    fsrw_host host (.*);
    // array model: byte derived from its address
    assign arr_data = rd_addr[7:0] ^ 8'h5a;

    initial begin
        forever #50 sys_clk = ~sys_clk;
    end

    // count one-cycle strobes so none is missed; also cut a hang short
    always @(posedge sys_clk) begin
        ticks++;
        if (prog_go === 1'b1) n_pg++;
        if (erase_go === 1'b1) n_eg++;
        if (eng_suspend === 1'b1) n_sus++;
        if (eng_resume === 1'b1) n_res++;
        if (ticks == 5000) begin
            miscompares++;
            conclude();
        end
    end

    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk);
    endtask

    task automatic chk(input string nm, input logic [23:0] seen, input logic [23:0] exp);
        num_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("BAD %s exp %h seen %h", nm, exp, seen);
        end
    endtask

    // frame then wait out the two-flop sync and output register
    task automatic fr(input logic [7:0] op, input int n, input logic [7:0] wb);
        host.frame(op, n, wb);
        cyc(6);
    endtask

    task automatic req(input bit e, input logic [23:0] a);
        req_addr <= a;
        erase_req <= e;
        prog_req <= !e;
        @(posedge sys_clk);
        erase_req <= 1'b0;
        prog_req <= 1'b0;
        cyc(4);
    endtask

    task automatic finish_op;
        cyc(200);
        op_done <= 1'b1;
        @(posedge sys_clk);
        op_done <= 1'b0;
        cyc(4);
    endtask

    // read from a with n steps; m says the final byte must be masked
    task automatic rd(input logic [23:0] a, input bit q, input int n, input logic [23:0] ea, input bit m);
        rd_start <= 1'b1;
        rd_start_addr <= a;
        rd_quad <= q;
        @(posedge sys_clk);
        rd_start <= 1'b0;
        if (n > 0) begin
            rd_step <= 1'b1;
            repeat (n) @(posedge sys_clk);
            rd_step <= 1'b0;
        end
        cyc(3);
        chk("rd addr", rd_addr, ea);
        chk("rd data", rd_data, m ? 8'hff : ea[7:0] ^ 8'h5a);
    endtask

    task automatic conclude;
        $display("checks %0d miscompares %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // main sequence
    initial begin
        rst_n <= 1'b0; // a real falling edge, so the link flops clear too
        cyc(2);
        rst_n <= 1'b1;
        cyc(3);
        chk("wrap reset", wrap_enable, 0);
        req(0, 24'h000120);
        chk("prog go", n_pg, 1);
        fr(ANY_SUSPENDED_FLAG, 7, 8'h00);
        chk("short any_suspended_flag", program_suspended_flag, 0);
        op_can_suspend <= 1'b0;
        fr(ANY_SUSPENDED_FLAG, 8, 8'h00);
        chk("no any_suspended_flag", n_sus, 0);
        op_can_suspend <= 1'b1;
        fr(ANY_SUSPENDED_FLAG, 8, 8'h00);
        chk("any_suspended_flag", {program_suspended_flag, any_suspended_flag, busy_flag}, 3'b110);
        req(1, 24'h010000);
        chk("erase held off", n_eg, 0);
        rd(24'h0000ff, 0, 0, 24'h0000ff, 0);
        rd(24'h0000ff, 0, 1, 24'h000100, 1);
        rd(24'h0001ff, 0, 1, 24'h000200, 0);
        rd(24'h000120, 0, 0, 24'h000120, 1);
        fr(8'h7a, 7, 8'h00);
        chk("short res", program_suspended_flag, 1);
        fr(8'h7a, 8, 8'h00);
        chk("res", {program_suspended_flag, any_suspended_flag, busy_flag, resume_pending}, 4'h3);
        chk("res pulse", n_res, 1);
        fr(ANY_SUSPENDED_FLAG, 8, 8'h00);
        chk("any_suspended_flag in latency", n_sus, 1);
        fr(8'h7a, 8, 8'h00);
        chk("res when busy", n_res, 1);
        finish_op();
        req(1, 24'h020000);
        chk("erase go", n_eg, 1);
        fr(ANY_SUSPENDED_FLAG, 8, 8'h00);
        rd(24'h020ffe, 0, 2, 24'h021000, 0);
        rd(24'h020800, 0, 0, 24'h020800, 1);
        req(0, 24'h030000);
        chk("prog in erase hold", n_pg, 2);
        fr(ANY_SUSPENDED_FLAG, 8, 8'h00);
        chk("both held", {erase_suspended_flag, program_suspended_flag}, 2'b11);
        fr(8'hd0, 8, 8'h00);
        chk("prog first", {erase_suspended_flag, program_suspended_flag, eng_resume_is_erase}, 3'b100);
        fr(8'h7a, 8, 8'h00);
        chk("res busy held", {erase_suspended_flag, n_res[1:0]}, 3'b110);
        finish_op();
        fr(8'h7a, 8, 8'h00);
        chk("erase res", {erase_suspended_flag, eng_resume_is_erase, any_suspended_flag}, 3'b010);
        finish_op();
        for (int i = 0; i < 4; i++) begin
            fr(8'h77, 16, {1'b1, 2'(i), 1'b0, 4'hf});
            chk("wrap len", {wrap_enable, wrap_len_sel}, {1'b1, 2'(i)});
        end
        fr(8'h77, 15, 8'h10);
        chk("short wrap", {wrap_enable, wrap_len_sel}, 3'b111);
        fr(8'h77, 16, 8'h20);
        rd(24'h001004, 1, 12, 24'h001000, 0);
        rd(24'h001004, 0, 12, 24'h001010, 0);
        fr(8'h77, 16, 8'h10);
        chk("wrap off", wrap_enable, 0);
        rd(24'h001004, 1, 12, 24'h001010, 0);
        conclude();
    end
endmodule

`default_nettype wire
